// [core/srp_pkg.sv]
// Constants, register map and field layout of the serial register access port
package srp_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned SRP_ADDR_W    = 6;
  localparam int unsigned SRP_DATA_W    = 16;
  localparam int unsigned SRP_HDR_BITS  = 8;
  localparam int unsigned SRP_CNT_W     = 5;
  localparam logic [4:0]  SRP_ADDR_LAST = 5'h06;  // Count at the last address bit
  localparam logic [4:0]  SRP_HDR_LAST  = 5'h07;  // Count at the header parity bit
  localparam logic [4:0]  SRP_WORD_LAST = 5'h0F;  // Count at the last data bit
  localparam logic        SRP_RW_WRITE  = 1'b0;
  localparam logic        SRP_RW_READ   = 1'b1;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] SRP_OFF_DEVICE_STATUS     = 6'h00;
  localparam logic [5:0] SRP_OFF_DEVICE_RAW_STATUS = 6'h02;
  localparam logic [5:0] SRP_OFF_THERMAL_STATUS    = 6'h04;
  localparam logic [5:0] SRP_OFF_SUPPLY_STATUS     = 6'h05;
  localparam logic [5:0] SRP_OFF_DRIVER_STATUS     = 6'h06;
  localparam logic [5:0] SRP_OFF_INTERFACE_STATUS  = 6'h07;
  localparam logic [5:0] SRP_OFF_FAULT_RESP_MODE   = 6'h10;
  localparam logic [5:0] SRP_OFF_SYS_FAULT_CTRL    = 6'h12;
  localparam logic [5:0] SRP_OFF_DRV_FAULT_CTRL    = 6'h13;
  localparam logic [5:0] SRP_OFF_FAULT_TIMING_CTRL = 6'h16;
  localparam logic [5:0] SRP_OFF_FAULT_CLEAR_CMD   = 6'h17;
  localparam logic [5:0] SRP_OFF_SUPPLY_WARN_THR   = 6'h18;
  localparam logic [5:0] SRP_OFF_PULSE_WIDTH_CTRL  = 6'h20;
  localparam logic [5:0] SRP_OFF_PREDRIVER_CTRL    = 6'h22;
  localparam logic [5:0] SRP_OFF_CURRENT_SENSE_CTRL = 6'h23;
  localparam logic [5:0] SRP_OFF_SYSTEM_CONTROL    = 6'h3F;

  // Stored read/write registers (the clear command is not stored)
  localparam int unsigned SRP_NUM_RW = 9;
  localparam logic [5:0] SRP_RW_OFFS [0:SRP_NUM_RW-1] = '{
    SRP_OFF_FAULT_RESP_MODE, SRP_OFF_SYS_FAULT_CTRL, SRP_OFF_DRV_FAULT_CTRL,
    SRP_OFF_FAULT_TIMING_CTRL, SRP_OFF_SUPPLY_WARN_THR, SRP_OFF_PULSE_WIDTH_CTRL,
    SRP_OFF_PREDRIVER_CTRL, SRP_OFF_CURRENT_SENSE_CTRL, SRP_OFF_SYSTEM_CONTROL};
  localparam logic [15:0] SRP_RW_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SRP_DEV_STATUS_RESET = 16'h0280;
  localparam int unsigned SRP_DS_PARITY     = 15;
  localparam int unsigned SRP_DS_NOT_READY  = 9;
  localparam int unsigned SRP_DS_OTP_LOAD   = 8;
  localparam int unsigned SRP_DS_POWER_ON   = 7;
  localparam int unsigned SRP_DS_SERIAL     = 6;
  localparam int unsigned SRP_DS_OVERCUR    = 5;
  localparam int unsigned SRP_DS_UV_WARN    = 4;
  localparam int unsigned SRP_DS_OVERVOLT   = 3;
  localparam int unsigned SRP_DS_UNDERVOLT  = 2;
  localparam int unsigned SRP_DS_OVERTEMP   = 1;
  localparam int unsigned SRP_DS_FAULT      = 0;
  localparam int unsigned SRP_IS_PARITY_ERR = 0;
  localparam int unsigned SRP_IS_FRAME_ERR  = 1;
  localparam int unsigned SRP_SC_PARITY_EN  = 0;
  localparam int unsigned SRP_FM_SERIAL_MODE = 0;
  localparam int unsigned SRP_FC_CLEAR      = 0;

endpackage : srp_pkg

// [core/srp_port.sv]
// Serial register access port with status and fault flags
`timescale 1ns/1ns

module srp_port (
  input  wire logic mclk_in,            // System clock, 25 MHz
  input  wire logic rst_in,             // Synchronous reset, active high
  input  wire logic sclk_in,            // Serial clock from controller
  input  wire logic cs_in_n,            // Frame select, active low
  input  wire logic sdi_in,             // Serial data in
  output logic      sdo_out,            // Serial data out
  output logic      sdo_oe_out,         // Serial data out enable
  input  wire logic sleep_in_n,         // Sleep pin, low-high pulse clears flags
  input  wire logic not_ready_in,       // Device not ready level
  input  wire logic otp_load_fault_in,  // OTP load fault event
  input  wire logic overcurrent_in,     // Overcurrent event
  input  wire logic undervoltage_warn_in, // Supply undervoltage warning event
  input  wire logic overvoltage_in,     // Overvoltage event
  input  wire logic undervoltage_in,    // Undervoltage event
  input  wire logic overtemp_in,        // Overtemperature event
  output logic      parity_check_enable_out, // Parity checking enabled
  output logic      fault_out_n         // Fault indication, active low
);
  import srp_pkg::*;

  // ----------------------------------------------------------------
  // Serial edge detection
  // ----------------------------------------------------------------
  logic sclk_prev_reg;
  logic cs_prev_reg;
  logic sel;
  logic rise;
  logic fall;
  logic frame_start;
  logic frame_stop;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_in;
      cs_prev_reg   <= cs_in_n;
    end
  end

  assign sel         = ~cs_in_n;
  assign rise        = sel & sclk_in & ~sclk_prev_reg;
  assign fall        = sel & ~sclk_in & sclk_prev_reg;
  assign frame_start = ~cs_in_n & cs_prev_reg;
  assign frame_stop  = cs_in_n & ~cs_prev_reg;

  // ----------------------------------------------------------------
  // Receive shifter and bit counters
  // ----------------------------------------------------------------
  logic [SRP_DATA_W-1:0] rx_reg;
  logic [SRP_DATA_W-1:0] rx_next;
  logic [SRP_CNT_W-1:0]  cnt_reg;
  logic                  hdr_done_reg;
  logic                  word_seen_reg;
  logic                  is_read_reg;
  logic                  addr_rdy;
  logic                  hdr_end;
  logic                  word_end;
  logic                  hdr_ok;
  logic                  word_ok;
  logic                  incomplete;

  assign rx_next  = {rx_reg[SRP_DATA_W-2:0], sdi_in};
  assign addr_rdy = rise & ~hdr_done_reg & (cnt_reg == SRP_ADDR_LAST);
  assign hdr_end  = rise & ~hdr_done_reg & (cnt_reg == SRP_HDR_LAST);
  assign word_end = rise & hdr_done_reg & (cnt_reg == SRP_WORD_LAST);
  assign hdr_ok   = ~^rx_next[SRP_HDR_BITS-1:0];
  assign word_ok  = ~^rx_next;
  assign incomplete = (cnt_reg != '0) | (hdr_done_reg & ~word_seen_reg);

  always_ff @(posedge mclk_in) begin
    if (rst_in || frame_start) begin
      rx_reg        <= '0;
      cnt_reg       <= '0;
      hdr_done_reg  <= 1'b0;
      word_seen_reg <= 1'b0;
    end else if (rise) begin
      rx_reg <= rx_next;
      if (hdr_end || word_end) begin
        cnt_reg      <= '0;
        hdr_done_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 5'h01;
      end
      if (word_end) begin
        word_seen_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      is_read_reg <= 1'b0;
    end else if (addr_rdy) begin
      is_read_reg <= (rx_next[SRP_ADDR_W] == SRP_RW_READ);
    end
  end

  // ----------------------------------------------------------------
  // Register storage and read mux
  // ----------------------------------------------------------------
  logic [SRP_DATA_W-1:0] rw_mem [0:SRP_NUM_RW-1];
  logic [SRP_DATA_W-1:0] dev_status;
  logic [SRP_DATA_W-1:0] intf_status;
  logic [SRP_DATA_W-1:0] system_control;
  logic [SRP_DATA_W-1:0] fault_mode;
  logic [SRP_ADDR_W-1:0] rd_ptr_reg;
  logic [SRP_ADDR_W-1:0] wr_ptr_reg;
  logic                  blocked_reg;
  logic                  pen;
  logic                  serial_fault_report_mode;
  logic                  wr_en;
  logic [SRP_DATA_W-1:0] rd_raw;
  logic [SRP_DATA_W-1:0] rd_word;

  assign pen  = system_control[SRP_SC_PARITY_EN];
  assign serial_fault_report_mode = fault_mode[SRP_FM_SERIAL_MODE];
  // Dummy words of a read are checked too, but never written
  assign wr_en = word_end & ~is_read_reg & ~blocked_reg & (word_ok | ~pen);

  genvar gi;
  generate
    for (gi = 0; gi < SRP_NUM_RW; gi++) begin : g_rw
      always_ff @(posedge mclk_in) begin
        if (rst_in) begin
          rw_mem[gi] <= SRP_RW_RESET;
        end else if (wr_en && wr_ptr_reg == SRP_RW_OFFS[gi]) begin
          rw_mem[gi] <= rx_next;
        end
      end
    end
  endgenerate

  always_comb begin
    system_control   = '0;
    fault_mode = '0;
    for (int i = 0; i < SRP_NUM_RW; i++) begin
      if (SRP_RW_OFFS[i] == SRP_OFF_SYSTEM_CONTROL) begin
        system_control = rw_mem[i];
      end
      if (SRP_RW_OFFS[i] == SRP_OFF_FAULT_RESP_MODE) begin
        fault_mode = rw_mem[i];
      end
    end
  end

  always_comb begin
    rd_raw = '0;
    if (rd_ptr_reg == SRP_OFF_DEVICE_STATUS) begin
      rd_raw = dev_status;
    end else if (rd_ptr_reg == SRP_OFF_INTERFACE_STATUS) begin
      rd_raw = intf_status;
    end else begin
      for (int i = 0; i < SRP_NUM_RW; i++) begin
        if (rd_ptr_reg == SRP_RW_OFFS[i]) begin
          rd_raw = rw_mem[i];
        end
      end
    end
    rd_word = rd_raw;
    if (pen) begin
      rd_word[SRP_DATA_W-1] = ^rd_raw[SRP_DATA_W-2:0];
    end
  end

  // ----------------------------------------------------------------
  // Address pointers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_ptr_reg <= '0;
    end else if (addr_rdy && rx_next[SRP_ADDR_W] == SRP_RW_READ) begin
      rd_ptr_reg <= rx_next[SRP_ADDR_W-1:0];
    end else if (word_end) begin
      rd_ptr_reg <= rd_ptr_reg + 6'h01;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wr_ptr_reg <= '0;
    end else if (hdr_end && !is_read_reg && (hdr_ok || !pen)) begin
      wr_ptr_reg <= rx_next[SRP_HDR_BITS-2:1];
    end else if (word_end && !blocked_reg && (word_ok || !pen)) begin
      wr_ptr_reg <= wr_ptr_reg + 6'h01;
    end
  end

  // One parity error blocks the writes of the rest of the frame
  always_ff @(posedge mclk_in) begin
    if (rst_in || frame_start) begin
      blocked_reg <= 1'b0;
    end else if (pen && ((hdr_end && !hdr_ok) || (word_end && !word_ok))) begin
      blocked_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifter
  // ----------------------------------------------------------------
  logic [SRP_DATA_W-1:0] tx_reg;
  logic                  reload_reg;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tx_reg     <= '0;
      reload_reg <= 1'b0;
      sdo_oe_out <= 1'b0;
    end else begin
      sdo_oe_out <= sel;
      if (frame_start) begin
        tx_reg     <= {dev_status[SRP_HDR_BITS-1:0], 8'h00};
        reload_reg <= 1'b0;
      end else if (hdr_end || word_end) begin
        reload_reg <= 1'b1;
      end else if (fall) begin
        reload_reg <= 1'b0;
        if (reload_reg) begin
          tx_reg <= rd_word;
        end else begin
          tx_reg <= {tx_reg[SRP_DATA_W-2:0], 1'b0};
        end
      end
    end
  end

  assign sdo_out = tx_reg[SRP_DATA_W-1];

  // ----------------------------------------------------------------
  // Latched fault flags
  // ----------------------------------------------------------------
  logic sleep_prev_reg;
  logic sleep_pulse;
  logic clr;
  logic par_evt;
  logic frm_evt;
  logic [7:0] evt;
  logic [7:0] flags_reg;    // 7=summary fault, 6..0 as packed in evt
  logic par_err_reg;
  logic frame_error_flag_reg;
  logic not_ready_reg;
  logic any_evt;

  assign sleep_pulse = sleep_in_n & ~sleep_prev_reg;
  assign clr = sleep_pulse | (wr_en && wr_ptr_reg == SRP_OFF_FAULT_CLEAR_CMD
                              && rx_next[SRP_FC_CLEAR]);
  assign par_evt = ~serial_fault_report_mode & pen &
                   ((hdr_end & ~hdr_ok) | (word_end & ~word_ok));
  assign frm_evt = ~serial_fault_report_mode & frame_stop & incomplete;
  // Packed as: otp, serial, overcurrent, uv warn, overvolt, undervolt, overtemp
  assign evt = {1'b0, otp_load_fault_in, par_evt | frm_evt, overcurrent_in,
                undervoltage_warn_in, overvoltage_in, undervoltage_in, overtemp_in};
  assign any_evt = |evt;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sleep_prev_reg <= 1'b1;
      not_ready_reg  <= 1'b1;
    end else begin
      sleep_prev_reg <= sleep_in_n;
      not_ready_reg  <= not_ready_in;
    end
  end

  // Set wins over clear so an event in the clear cycle survives
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      flags_reg   <= 8'h00;
      par_err_reg <= 1'b0;
      frame_error_flag_reg <= 1'b0;
    end else begin
      flags_reg   <= (clr ? 8'h00 : flags_reg) | evt | {any_evt, 7'h00};
      par_err_reg <= (par_err_reg & ~clr) | par_evt;
      frame_error_flag_reg <= (frame_error_flag_reg & ~clr) | frm_evt;
    end
  end

  logic power_on_reg;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      power_on_reg <= 1'b1;
    end else if (clr) begin
      power_on_reg <= 1'b0;
    end
  end

  always_comb begin
    dev_status = '0;
    dev_status[SRP_DS_NOT_READY] = not_ready_reg;
    dev_status[SRP_DS_OTP_LOAD]  = flags_reg[6];
    dev_status[SRP_DS_POWER_ON]  = power_on_reg;
    dev_status[SRP_DS_SERIAL]    = flags_reg[5];
    dev_status[SRP_DS_OVERCUR]   = flags_reg[4];
    dev_status[SRP_DS_UV_WARN]   = flags_reg[3];
    dev_status[SRP_DS_OVERVOLT]  = flags_reg[2];
    dev_status[SRP_DS_UNDERVOLT] = flags_reg[1];
    dev_status[SRP_DS_OVERTEMP]  = flags_reg[0];
    dev_status[SRP_DS_FAULT]     = flags_reg[7] | (|flags_reg[6:0]);
    intf_status = '0;
    intf_status[SRP_IS_PARITY_ERR] = par_err_reg;
    intf_status[SRP_IS_FRAME_ERR]  = frame_error_flag_reg;
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fault_out_n             <= 1'b1;
      parity_check_enable_out <= 1'b0;
    end else begin
      fault_out_n             <= ~(|flags_reg);
      parity_check_enable_out <= pen;
    end
  end

endmodule : srp_port

// [verif/srp_port_properties.sv]
// Concurrent checks of the serial register access port pins
`timescale 1ns/1ns
module srp_chk (
  input wire logic mclk_in,                 // Clock
  input wire logic rst_in,                  // Reset
  input wire logic sclk_in,                 // Serial clock
  input wire logic cs_in_n,                 // Select
  input wire logic sdo_out,                 // Data out
  input wire logic sdo_oe_out,              // Out enable
  input wire logic sleep_in_n,              // Sleep pin
  input wire logic otp_load_fault_in,       // Event
  input wire logic overcurrent_in,          // Event
  input wire logic undervoltage_warn_in,    // Event
  input wire logic overvoltage_in,          // Event
  input wire logic undervoltage_in,         // Event
  input wire logic overtemp_in,             // Event
  input wire logic parity_check_enable_out, // Parity on
  input wire logic fault_out_n              // Fault
);
  // ----------
  // Helpers
  // ----------
  logic       sclk_reg;
  logic [9:0] rise_reg;
  logic [2:0] quiet_reg;
  logic       any_ev;
  logic       frame_bad;
  assign any_ev = otp_load_fault_in | overcurrent_in | undervoltage_warn_in
                  | overvoltage_in | undervoltage_in | overtemp_in;
  // Complete frame: header plus at least one whole word; an empty select pulse is ignored
  assign frame_bad = (rise_reg != 10'h000) && ((rise_reg < 10'h009) || (rise_reg[3:0] != 4'h8));
  always_ff @(posedge mclk_in) begin
    sclk_reg <= rst_in ? 1'b0 : sclk_in;
  end
  always_ff @(posedge mclk_in) begin
    if (rst_in || cs_in_n) begin
      rise_reg <= 10'h000;
    end else if (sclk_in && !sclk_reg) begin
      rise_reg <= rise_reg + 10'h001;
    end
  end
  // Cycles since a frame or sleep pulse, the only legal clear sources
  always_ff @(posedge mclk_in) begin
    if (rst_in || !cs_in_n || !sleep_in_n) begin
      quiet_reg <= 3'h0;
    end else if (quiet_reg != 3'h7) begin
      quiet_reg <= quiet_reg + 3'h1;
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  // ----------
  // Checks
  // ----------
  a_reset_quiet: assert property (rst_in |=> !sdo_oe_out && fault_out_n
    && !parity_check_enable_out) else $error("outputs not quiet in reset");
  a_oe_follows_cs: assert property (disable iff (rst_in)
    1 |=> sdo_oe_out == !$past(cs_in_n)) else $error("enable not following select");
  a_event_fault: assert property (disable iff (rst_in)
    any_ev |-> ##[1:3] !fault_out_n) else $error("event not reported");
  a_flags_hold: assert property (disable iff (rst_in)
    !fault_out_n && quiet_reg >= 3'h4 |=> !fault_out_n) else $error("fault dropped");
  a_pen_steady: assert property (disable iff (rst_in)
    $changed(parity_check_enable_out) |-> quiet_reg < 3'h4) else $error("parity enable moved");
  a_sdo_steady: assert property (disable iff (rst_in)
    !cs_in_n && !$past(cs_in_n) && sclk_in && $past(sclk_in) |-> $stable(sdo_out))
    else $error("data out moved while clock high");
  a_frame_err: assert property (disable iff (rst_in)
    $rose(cs_in_n) && frame_bad |-> ##[1:4] !fault_out_n) else $error("frame error missed");
  a_sleep_clear: assert property (disable iff (rst_in)
    $rose(sleep_in_n) && cs_in_n && !any_ev ##1 (cs_in_n && !any_ev) [*4] |-> fault_out_n)
    else $error("sleep pulse did not clear");
  c_frame_bad: cover property ($rose(cs_in_n) && frame_bad);
  c_sleep: cover property ($rose(sleep_in_n));
  c_pen_on: cover property ($rose(parity_check_enable_out));
endmodule : srp_chk
bind srp_port srp_chk u_chk (.mclk_in, .rst_in, .sclk_in, .cs_in_n, .sdo_out, .sdo_oe_out,
  .sleep_in_n, .otp_load_fault_in, .overcurrent_in, .undervoltage_warn_in, .overvoltage_in,
  .undervoltage_in, .overtemp_in, .parity_check_enable_out, .fault_out_n);

// [verif/srp_primary.sv]
// Behavioural serial primary that frames and shifts words into the port
`timescale 1ns/1ns
module srp_primary (
  input  wire logic mclk_in,  // Clock
  input  wire logic sdo_in,   // Data from port
  output logic      sclk_out, // Serial clock
  output logic      cs_out_n, // Select
  output logic      sdi_out   // Data to port
);
  int half = 4;  // Cycles per half period; 2 is the fastest legal
  initial begin
    sclk_out = 1'b0;
    cs_out_n = 1'b1;
    sdi_out  = 1'b0;
  end
  task automatic pause(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : pause
  task automatic start();
    pause(2);
    cs_out_n = 1'b0;
    pause(half);
  endtask : start
  // MSB first; data out taken on each rising serial edge
  task automatic shift(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_out = tx[i];
      pause(half);
      sclk_out = 1'b1;
      rx = {rx[14:0], sdo_in};
      pause(half);
      sclk_out = 1'b0;
    end
  endtask : shift
  // Released line inverts so a stale bit never passes for data
  task automatic stop();
    pause(2);
    cs_out_n = 1'b1;
    sdi_out  = ~sdi_out;
    pause(3);
  endtask : stop
endmodule : srp_primary

// [verif/testbench.sv]
// Self-checking bench for the serial register access port
`timescale 1ns/1ns
module testbench;
  logic        mclk_in, rst_in, sleep_in_n, not_ready_in;
  logic        sclk, cs_n, sdi, sdo, sdo_oe, pen, fault_n;
  logic [5:0]  ev;
  logic [15:0] rq [0:2];
  logic [7:0]  st;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  initial mclk_in = 1'b0;
  always #20 mclk_in = ~mclk_in;
  srp_port u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_in_n(cs_n),
    .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .sleep_in_n(sleep_in_n),
    .not_ready_in(not_ready_in), .otp_load_fault_in(ev[0]), .overcurrent_in(ev[1]),
    .undervoltage_warn_in(ev[2]), .overvoltage_in(ev[3]), .undervoltage_in(ev[4]),
    .overtemp_in(ev[5]), .parity_check_enable_out(pen), .fault_out_n(fault_n));
  // Undriven data line shows the inverse so a late enable cannot pass for data
  srp_primary u_pri (.mclk_in(mclk_in), .sdo_in(sdo_oe ? sdo : ~sdo), .sclk_out(sclk),
    .cs_out_n(cs_n),
    .sdi_out(sdi));
  // ----------
  // Helpers
  // ----------
  function automatic logic [7:0] hd(input logic rw, input logic [5:0] a);
    return {rw, a, ^{rw, a}};
  endfunction : hd
  function automatic logic [15:0] dw(input logic [15:0] d);
    return {^d[14:0], d[14:0]};
  endfunction : dw
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic frame(input logic [7:0] hdr, input int nw, input logic [15:0] w0 = 16'h0000,
                       input logic [15:0] w1 = 16'h0000);
    logic [15:0] r;
    // Scenarios write listed offsets only; one burst read runs on to reserved 6'h14
    u_pri.start();
    u_pri.shift({8'h00, hdr}, 8, r);
    st = r[7:0];
    for (int i = 0; i < nw; i++) begin
      u_pri.shift(i == 0 ? w0 : w1, 16, rq[i]);
    end
    u_pri.stop();
  endtask : frame
  task automatic rd(input logic [5:0] a, input int n);
    frame(hd(1'b1, a), n);
  endtask : rd
  task automatic want_fault(input logic lvl);
    int k;
    k = 0;
    while (fault_n !== lvl && k < 8) begin
      @(negedge mclk_in);
      k++;
    end
    check({15'h0000, fault_n}, {15'h0000, lvl});
  endtask : want_fault
  // ----------
  // Scenarios
  // ----------
  task automatic test_reset();
    rd(6'h00, 1);
    check({8'h00, st}, 16'h0080);
    check(rq[0], 16'h0280);
    check({15'h0000, pen}, 16'h0000);
  endtask : test_reset
  task automatic test_burst();
    frame(hd(1'b0, 6'h12), 2, 16'h1234, 16'h0007);
    rd(6'h12, 1);
    check(rq[0], 16'h1234);
    frame(hd(1'b0, 6'h04), 1, 16'h5555);
    check(rq[0], 16'h0007);
    rd(6'h12, 3);
    check(rq[0], 16'h1234);
    check(rq[1], 16'h0007);
    check(rq[2], 16'h0000);
    rd(6'h04, 1);
    check(rq[0], 16'h0000);
  endtask : test_burst
  task automatic test_parity();
    frame(hd(1'b0, 6'h3F), 1, dw(16'h0001));
    check({15'h0000, pen}, 16'h0001);
    u_pri.half = 2;
    rd(6'h13, 1);
    check(rq[0], dw(16'h0007));
    frame(hd(1'b0, 6'h12), 2, 16'h0001, dw(16'h0003));
    want_fault(1'b0);
    rd(6'h12, 2);
    check(rq[0], dw(16'h1234));
    check(rq[1], dw(16'h0007));
    frame(hd(1'b0, 6'h13) ^ 8'h01, 1, dw(16'h0003));
    frame(hd(1'b1, 6'h13) ^ 8'h01, 1);
    check(rq[0], dw(16'h0007));
    rd(6'h07, 1);
    check(rq[0], dw(16'h0001));
    rd(6'h00, 1);
    check(rq[0], dw(16'h02C1));
    u_pri.half = 4;
    frame(hd(1'b0, 6'h17), 1, dw(16'h0001));
    want_fault(1'b1);
    rd(6'h00, 1);
    check(rq[0], dw(16'h0200));
  endtask : test_parity
  task automatic test_quiet_mode();
    frame(hd(1'b0, 6'h10), 1, dw(16'h0001));
    frame(hd(1'b0, 6'h13), 1, 16'h0001);
    want_fault(1'b1);
    rd(6'h07, 1);
    check(rq[0], 16'h0000);
    rd(6'h13, 1);
    check(rq[0], dw(16'h0007));
    frame(hd(1'b0, 6'h10), 1, dw(16'h0000));
  endtask : test_quiet_mode
  task automatic test_frame_sleep();
    u_pri.start();
    u_pri.shift(16'h00A5, 4, rq[0]);
    u_pri.stop();
    want_fault(1'b0);
    rd(6'h07, 1);
    check(rq[0], dw(16'h0002));
    sleep_in_n = 1'b0;
    repeat (3) @(negedge mclk_in);
    sleep_in_n = 1'b1;
    repeat (6) @(negedge mclk_in);
    want_fault(1'b1);
    rd(6'h07, 1);
    check(rq[0], 16'h0000);
  endtask : test_frame_sleep
  task automatic test_events();
    int pos [0:5] = '{8, 5, 4, 3, 2, 1};
    for (int i = 0; i < 6; i++) begin
      ev[i] = 1'b1;
      @(negedge mclk_in);
      ev[i] = 1'b0;
      want_fault(1'b0);
      rd(6'h00, 1);
      check(rq[0], dw(16'h0201 | (16'h0001 << pos[i])));
      frame(hd(1'b0, 6'h17), 1, dw(16'h0001));
      want_fault(1'b1);
    end
    not_ready_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    rd(6'h00, 1);
    check(rq[0], 16'h0000);
  endtask : test_events
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    rst_in = 1'b1;
    sleep_in_n = 1'b1;
    not_ready_in = 1'b1;
    ev = 6'h00;
    repeat (2) @(negedge mclk_in);
    rst_in = 1'b0;
    test_reset();
    test_burst();
    test_parity();
    test_quiet_mode();
    test_frame_sleep();
    test_events();
    wrap_up();
  end
  // Whole run is about 7200 cycles
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("Error at %0t ns: timeout", $time);
      wrap_up();
    end
  end
endmodule : testbench
